// File: core/cdtc_pkg.sv
// shared constants for the no-auto-retransmit transmit-completion block
package cdtc_pkg;
    // number of transmit buffers by default
    localparam int unsigned CDTC_NUM_BUFS_DEF = 32;
    // smallest and largest buffer count the logic serves
    localparam int unsigned CDTC_NUM_BUFS_MIN = 2;
    localparam int unsigned CDTC_NUM_BUFS_MAX = 32;
    // buffer index taken as previously started after reset
    localparam int unsigned CDTC_PREV_IDX_RST = 0;
    // reset values of the flag vectors
    localparam logic        CDTC_FLAG_RST     = 1'h0;
    // attempt sequencer states
    typedef enum logic [0:0] {
        CDTC_ST_IDLE,
        CDTC_ST_BUSY
    } cdtc_state_t;
endpackage

// File: core/cdtc_buf_pick.sv
// lowest-index pending transmit buffer selector
`timescale 1ns/1ps
module cdtc_buf_pick
    import cdtc_pkg::*;
#(
    parameter int unsigned NUM_BUFS = CDTC_NUM_BUFS_DEF,
    parameter int unsigned IW       = $clog2(NUM_BUFS)
) (
    // candidate buffers
    input  wire logic [NUM_BUFS-1:0] pending,
    // selection result
    output logic                     found,
    output logic [IW-1:0]            idx
);
    // the index must be wide enough to name every buffer
    if (NUM_BUFS < 1 || IW < 1 || IW < $clog2(NUM_BUFS)) begin : g_chk
        $error("cdtc_buf_pick: IW too narrow for NUM_BUFS");
    end

    // scan from the top so the lowest pending index wins
    always_comb begin
        found = 1'b0;
        idx   = '0;
        for (int i = NUM_BUFS - 1; i >= 0; i--) begin
            if (pending[i]) begin
                found = 1'b1;
                idx   = IW'(i);
            end
        end
    end
endmodule

// File: core/cdtc_top.sv
// transmit-completion flag handling with the early arbitration-loss anomaly
`timescale 1ns/1ps
//
// Contract
// R1: no auto retransmit after failure in that mode
// R2: failure clears pending, sets cancel-done flag
// R3: early arbitration loss updates previously started buffer
// R4: buffer left pending is transmitted once more
// R5: repeated early loss updates the same buffer
// R6: bus errors always update the transmitted buffer
// R7: at most one extra retransmission per buffer
// R8: track last started buffer, reset to zero
module cdtc_top
    import cdtc_pkg::*;
#(
    parameter int unsigned NUM_BUFS = CDTC_NUM_BUFS_DEF,
    parameter int unsigned IW       = $clog2(NUM_BUFS)
) (
    // clock and reset
    input  wire logic                sys_clk,
    input  wire logic                rst,
    // configuration
    input  wire logic                no_auto_retransmit_mode,
    // software request pulses, one bit per buffer
    input  wire logic [NUM_BUFS-1:0] req_set,
    // attempt outcome from the protocol engine, one-cycle pulses plus an early-loss qualifier
    input  wire logic                tx_ok,
    input  wire logic                bus_err,
    input  wire logic                arb_lost,
    input  wire logic                arb_lost_early,
    // attempt control towards the protocol engine
    output logic                     attempt_start,
    output logic [IW-1:0]            attempt_buf,
    output logic                     attempt_active,
    // flag vectors seen by software
    output logic [NUM_BUFS-1:0]      tx_pending_flags,
    output logic [NUM_BUFS-1:0]      tx_cancel_done_flags,
    output logic [NUM_BUFS-1:0]      tx_done_flags
);
    // refuse buffer counts the index logic cannot serve
    if (NUM_BUFS < CDTC_NUM_BUFS_MIN || NUM_BUFS > CDTC_NUM_BUFS_MAX) begin : g_chk
        $error("cdtc_top: NUM_BUFS out of range");
    end
    // a hand-set index width that differs from the buffer count would alias buffers
    if (IW != $clog2(NUM_BUFS)) begin : g_chk_iw
        $error("cdtc_top: IW does not match NUM_BUFS");
    end

    cdtc_state_t         state_r;        // sequencer state
    logic [IW-1:0]       cur_buf_r;      // buffer of the running attempt
    logic [IW-1:0]       prev_buf_r;     // buffer started before it
    logic [IW-1:0]       last_buf_r;     // most recently started buffer
    logic [NUM_BUFS-1:0] pend_r;         // request-pending flags
    logic [NUM_BUFS-1:0] cdone_r;        // cancellation-finished flags
    logic [NUM_BUFS-1:0] done_r;         // transmission-done flags
    logic                start_r;        // attempt start pulse
    logic                active_r;       // attempt in progress, kept for the output
    logic                pick_found;     // some buffer is pending
    logic [IW-1:0]       pick_idx;       // lowest pending buffer
    logic                outcome;        // attempt ends this cycle
    logic                fail_ev;        // attempt failed in no-retry mode
    logic                misdir;         // failure lands on previous buffer
    logic [IW-1:0]       fail_tgt;       // buffer whose flags are updated
    logic [NUM_BUFS-1:0] one_cur;        // one-hot of running buffer
    logic [NUM_BUFS-1:0] one_tgt;        // one-hot of update target
    logic [NUM_BUFS-1:0] hw_clr;         // pending bits cleared by hardware
    logic [NUM_BUFS-1:0] cd_set;         // cancel-done bits set by hardware
    logic [NUM_BUFS-1:0] ok_set;         // done bits set by hardware

    // pending buffer selection
    cdtc_buf_pick #(
        .NUM_BUFS (NUM_BUFS),
        .IW       (IW)
    ) u_pick (
        .pending  (pend_r),
        .found    (pick_found),
        .idx      (pick_idx)
    );

    // outcome decode and update targets
    always_comb begin
        outcome  = (state_r == CDTC_ST_BUSY) && (tx_ok || bus_err || arb_lost);
        // a bus error takes precedence over a lost arbitration
        fail_ev  = outcome && !tx_ok && no_auto_retransmit_mode; // R1
        misdir   = fail_ev && !bus_err && arb_lost && arb_lost_early; // R3 R6
        fail_tgt = misdir ? prev_buf_r : cur_buf_r; // R3 R5 R6 R7
        one_cur  = {{(NUM_BUFS-1){1'b0}}, 1'b1} << cur_buf_r;
        one_tgt  = {{(NUM_BUFS-1){1'b0}}, 1'b1} << fail_tgt;
        hw_clr   = '0;
        cd_set   = '0;
        ok_set   = '0;
        if (outcome && tx_ok) begin
            // success retires the running buffer
            hw_clr = one_cur;
            ok_set = one_cur;
        end else if (fail_ev) begin
            // failure in no-retry mode cancels the target buffer
            hw_clr = one_tgt; // R2
            cd_set = one_tgt; // R2
        end
    end

    // sequencer: start lowest pending buffer, wait for its outcome
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_r  <= CDTC_ST_IDLE;
            start_r  <= 1'b0;
            active_r <= 1'b0;
        end else begin
            start_r <= 1'b0;
            case (state_r)
                CDTC_ST_IDLE: begin
                    // a still-pending buffer is simply picked again
                    if (pick_found) begin // R4
                        state_r  <= CDTC_ST_BUSY;
                        start_r  <= 1'b1;
                        active_r <= 1'b1;
                    end
                end
                CDTC_ST_BUSY: begin
                    // outside no-retry mode a failed buffer stays pending
                    if (outcome) begin
                        state_r  <= CDTC_ST_IDLE;
                        active_r <= 1'b0;
                    end
                end
                default: begin
                    // unreachable code: fall back to idle with no attempt open
                    state_r  <= CDTC_ST_IDLE;
                    active_r <= 1'b0;
                end
            endcase
        end
    end

    // buffer index tracking
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cur_buf_r  <= IW'(CDTC_PREV_IDX_RST);
            prev_buf_r <= IW'(CDTC_PREV_IDX_RST);
            last_buf_r <= IW'(CDTC_PREV_IDX_RST);
        end else if (state_r == CDTC_ST_IDLE && pick_found) begin
            // previous is whatever was started last, buffer 0 before any
            cur_buf_r  <= pick_idx;
            prev_buf_r <= last_buf_r; // R8
            last_buf_r <= pick_idx;   // R8
        end
    end

    // request-pending flags: a new request wins over a hardware clear
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pend_r <= {NUM_BUFS{CDTC_FLAG_RST}};
        end else begin
            pend_r <= (pend_r & ~hw_clr) | req_set; // R2
        end
    end

    // completion flags: hardware set wins over clear by a new request
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cdone_r <= {NUM_BUFS{CDTC_FLAG_RST}};
            done_r  <= {NUM_BUFS{CDTC_FLAG_RST}};
        end else begin
            cdone_r <= (cdone_r & ~req_set) | cd_set; // R2
            done_r  <= (done_r & ~req_set) | ok_set;
        end
    end

    // outputs straight from flip-flops
    assign attempt_start        = start_r;
    assign attempt_buf          = cur_buf_r;
    assign attempt_active       = active_r;
    assign tx_pending_flags     = pend_r;
    assign tx_cancel_done_flags = cdone_r;
    assign tx_done_flags        = done_r;

    // helper: buffer left pending by a misdirected update
    logic          extra_v_r;   // an extra retry is owed
    logic [IW-1:0] extra_buf_r; // the buffer that owes it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            extra_v_r   <= 1'b0;
            extra_buf_r <= '0;
        end else if (misdir && prev_buf_r != cur_buf_r) begin
            extra_v_r   <= 1'b1;
            extra_buf_r <= cur_buf_r;
        end else if (outcome && extra_v_r && cur_buf_r == extra_buf_r) begin
            extra_v_r   <= 1'b0;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    AST_NO_RETRY: assert property ( // R1
        fail_ev && !misdir && !req_set[cur_buf_r] |=> !pend_r[$past(cur_buf_r)])
        else $error("failed buffer still pending in no-retry mode");
    AST_CANCEL_SET: assert property ( // R2
        fail_ev && !misdir |=> cdone_r[$past(cur_buf_r)] && attempt_active == 1'b0)
        else $error("failed buffer not marked cancel-done");
    AST_MISDIRECT: assert property ( // R3
        misdir |=> cdone_r[$past(prev_buf_r)])
        else $error("early loss did not update previous buffer");
    AST_RETRY: assert property ( // R4
        misdir && prev_buf_r != cur_buf_r && !hw_clr[cur_buf_r] && pend_r[cur_buf_r]
        |-> ##[1:3] start_r)
        else $error("left pending buffer not retried");
    AST_SAME_BUF: assert property ( // R5
        misdir && prev_buf_r == cur_buf_r && !req_set[cur_buf_r]
        |=> !pend_r[$past(cur_buf_r)] && cdone_r[$past(cur_buf_r)])
        else $error("repeated early loss did not cancel buffer");
    AST_BUS_ERR: assert property ( // R6
        fail_ev && bus_err |-> !misdir ##1 cdone_r[$past(cur_buf_r)])
        else $error("bus error updated wrong buffer");
    AST_ONE_EXTRA: assert property ( // R7
        misdir && prev_buf_r != cur_buf_r |-> !(extra_v_r && extra_buf_r == cur_buf_r))
        else $error("more than one extra retransmission");
    AST_TRACK: assert property ( // R8
        start_r |-> last_buf_r == cur_buf_r ##1 state_r == CDTC_ST_BUSY)
        else $error("last started buffer not tracked");

    COV_SUCCESS: cover property (outcome && tx_ok ##1 done_r != '0);
    COV_MISDIR: cover property (misdir && prev_buf_r != cur_buf_r);
    COV_RETRY_CANCEL: cover property (misdir && prev_buf_r != cur_buf_r
        ##[1:20] misdir && prev_buf_r == cur_buf_r);
    COV_BUS_ERR: cover property (fail_ev && bus_err);
endmodule

// File: verification/cdtc_bus_model.sv
// partner model: protocol engine and other nodes answering each attempt
`timescale 1ns/1ps
module cdtc_bus_model (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // attempt seen from the block
    input  wire logic       attempt_start,
    // outcome kind and extra delay chosen by the bench
    input  wire logic [1:0] code,
    input  wire logic [1:0] dly,
    // outcome pulses and the early-loss qualifier
    output logic            tx_ok,
    output logic            bus_err,
    output logic            arb_lost,
    output logic            arb_lost_early
);
    logic [1:0] cnt_r; // cycles left before the outcome
    logic       go;    // outcome fires at this edge
    // zero delay answers in the cycle right after the start pulse
    assign go = attempt_start ? (dly == 2'h0) : (cnt_r == 2'h1);
    // one outcome per attempt; the qualifier toggles while it means nothing
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_r          <= 2'h0;
            tx_ok          <= 1'b0;
            bus_err        <= 1'b0;
            arb_lost       <= 1'b0;
            arb_lost_early <= 1'b0;
        end else begin
            cnt_r          <= attempt_start ? dly : (cnt_r != 2'h0 ? cnt_r - 2'h1 : 2'h0);
            tx_ok          <= go && code == 2'h0;
            bus_err        <= go && code == 2'h1;
            arb_lost       <= go && code[1];
            arb_lost_early <= go ? code == 2'h3 : ~arb_lost_early;
        end
    end
endmodule

// File: verification/cdtc_top_bench.sv
// self-checking bench with a queue-free flag model of the completion logic
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module cdtc_top_bench;
    logic       sys_clk, rst, mode, tx_ok, bus_err, arb_lost, arb_early;
    logic       a_start, a_active;
    logic [1:0] code, dly, a_buf;
    logic [3:0] req_set, pend, canc, done, m_pend, m_canc, m_done;
    logic [15:0] lf;                    // random source
    int         fail_count, checks_done, prev_m, last_m;
    int         att [4];                // attempts per buffer since request
    cdtc_top #(.NUM_BUFS(4), .IW(2)) u_cdtc_top (.sys_clk(sys_clk), .rst(rst),
        .no_auto_retransmit_mode(mode), .req_set(req_set), .tx_ok(tx_ok),
        .bus_err(bus_err), .arb_lost(arb_lost), .arb_lost_early(arb_early),
        .attempt_start(a_start), .attempt_buf(a_buf), .attempt_active(a_active),
        .tx_pending_flags(pend), .tx_cancel_done_flags(canc), .tx_done_flags(done));
    cdtc_bus_model u_cdtc_bus_model (.sys_clk(sys_clk), .rst(rst), .attempt_start(a_start),
        .code(code), .dly(dly), .tx_ok(tx_ok), .bus_err(bus_err), .arb_lost(arb_lost),
        .arb_lost_early(arb_early));
    // 50 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // lowest pending buffer
    function automatic int low(input logic [3:0] p);
        low = 0;
        for (int i = 3; i >= 0; i--) if (p[i]) low = i;
    endfunction
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // request a mask, then follow every attempt; fc: 0..3 fixed, 4 cycling, -1 random
    task automatic run(input logic md, input logic [3:0] mask, input int fc);
        int k, b, t, w;
        logic [1:0] oc;
        mode = md;
        code = fc < 0 ? lf[1:0] : (fc == 4 ? 2'h0 : fc[1:0]);
        dly = lf[3:2];
        req_set = mask;
        @(posedge sys_clk) #2;
        req_set = 4'h0;
        m_pend |= mask;
        m_canc &= ~mask;
        m_done &= ~mask;
        foreach (att[i]) if (mask[i]) att[i] = 0;
        for (k = 1; k < 64 && m_pend != 4'h0; k++) begin
            for (w = 0; a_start !== 1'b1 && w < 20; w++) @(posedge sys_clk) #2;
            if (w == 20) begin fail_count++; end_sim; end
            b = low(m_pend);
            `CHK("attempt_buf", b[1:0], a_buf)
            `CHK("attempt_active", 1'b1, a_active)
            prev_m = last_m;
            last_m = b;
            att[b]++;
            if (md) `CHK("retry bound", 1'b1, att[b] <= 2)
            oc = code;
            w = 0;
            do begin @(posedge sys_clk) #2; w++; end
            while ((tx_ok | bus_err | arb_lost) !== 1'b1 && w < 20);
            if (w == 20) begin fail_count++; end_sim; end
            @(posedge sys_clk) #2;
            t = (oc == 2'h3) ? prev_m : b;
            if (oc == 2'h0) begin m_pend[b] = 1'b0; m_done[b] = 1'b1; end
            else if (md) begin m_pend[t] = 1'b0; m_canc[t] = 1'b1; end
            `CHK("pending", m_pend, pend)
            `CHK("cancel_done", m_canc, canc)
            `CHK("done", m_done, done)
            `CHK("active after outcome", 1'b0, a_active)
            lf = nxt(lf);
            code = fc < 0 ? lf[1:0] : (fc == 4 ? k[1:0] : fc[1:0]);
            dly = lf[3:2];
        end
        if (m_pend != 4'h0) begin fail_count++; end_sim; end
        $display("test done mode %0d mask %h", md, mask);
    endtask
    initial begin
        lf = 16'h002a;
        {rst, mode, req_set, code, dly} = {1'b1, 1'b0, 4'h0, 2'h0, 2'h0};
        {m_pend, m_canc, m_done} = 12'h000;
        {fail_count, checks_done, prev_m, last_m} = 128'h0;
        repeat (12) @(posedge sys_clk);
        #2 rst = 1'b0;
        `CHK("attempt_buf at reset", 2'h0, a_buf)
        `CHK("pending at reset", 4'h0, pend)
        run(1'b1, 4'hf, 4);
        run(1'b1, 4'h2, 3);
        run(1'b0, 4'hf, 4);
        repeat (20) begin
            lf = nxt(lf);
            run(lf[4] & ~lf[5], lf[11:8] | 4'h1, -1);
        end
        end_sim;
    end
endmodule
